// [shared/fsg_params.svh]
// Constants of the flash security command gate.
`ifndef FSG_PARAMS_SVH
`define FSG_PARAMS_SVH

`define FSG_BLK_CNT       8
`define FSG_BLK_W         3
`define FSG_SMALL_BLK_CNT 4
`define FSG_SMALL_BLK_KB  4
`define FSG_LARGE_BLK_KB  60
`define FSG_ADDR_W        18
`define FSG_SMALL_BYTES   18'h01000
`define FSG_LARGE_BYTES   18'h0f000
`define FSG_SEC_RST       3'h0
`define FSG_SEC_BLK_BIT   0
`define FSG_SEC_CHIP_BIT  1
`define FSG_SEC_PROG_BIT  2

`endif

// [shared/fsg_pkg.sv]
// Types of the flash security command gate.
package fsg_pkg;

	typedef enum logic [3:0] {
		FSG_CMD_NONE  = 4'h0,
		FSG_CMD_BLK   = 4'h1,
		FSG_CMD_CHIP  = 4'h2,
		FSG_CMD_PROG  = 4'h3,
		FSG_CMD_SEC   = 4'h4,
		FSG_CMD_READ  = 4'h5
	} fsg_cmd_e;

	typedef enum logic [3:0] {
		FSG_ST_IDLE = 4'h1,
		FSG_ST_BUSY = 4'h2,
		FSG_ST_DONE = 4'h4,
		FSG_ST_REJ  = 4'h8
	} fsg_state_e;

	typedef logic [2:0] fsg_sec_t;

endpackage

// [logic/fsg_blk_map.sv]
// Block number to flash address range decoder.
`timescale 1ns/1ps
`include "fsg_params.svh"

module fsg_blk_map (
	input  wire logic [`FSG_BLK_W-1:0]  blk,
	output logic      [`FSG_ADDR_W-1:0] base,
	output logic      [`FSG_ADDR_W-1:0] size
);

	// =====================================================
	// Address decode
	// Blocks 0 to 3 are small, the rest are large.
	always_comb begin
		if (blk < `FSG_BLK_W'(`FSG_SMALL_BLK_CNT)) begin
			base = `FSG_ADDR_W'(blk) * `FSG_SMALL_BYTES;
			size = `FSG_SMALL_BYTES;
		end else begin
			base = `FSG_ADDR_W'(`FSG_SMALL_BLK_CNT) * `FSG_SMALL_BYTES
				+ `FSG_ADDR_W'(blk - `FSG_BLK_W'(`FSG_SMALL_BLK_CNT)) * `FSG_LARGE_BYTES;
			size = `FSG_LARGE_BYTES;
		end
	end

endmodule

// [logic/fsg_gate.sv]
// Security gate for flash rewrite commands from the programmer and from self programming.
//
// Behaviour
// - Block erase prohibition rejects programmer block erase; chip erase and program allowed.
// - Successful chip erase clears the block erase prohibition.
// - Chip erase prohibition rejects programmer block erase and chip erase.
// - Once chip erase prohibition is set, no prohibition can ever be cleared.
// - Program prohibition rejects programmer writes and block erase; chip erase allowed.
// - Chip erase clears the program prohibition.
// - Prohibition settings are written only by the programmer in programmer mode.
// - Three independent flags; accepted commands are the intersection of restrictions.
// - Self programming leaves prohibition settings unchanged.
// - No self programming verify; user program may read flash contents.
// - Chip erase erases the whole array, programmer mode only.
// - Block erase covers only the given block: 4 KB blocks 0-3, 60 KB others.
`timescale 1ns/1ps
`include "fsg_params.svh"

module fsg_gate (
	input  wire logic                    core_clk,
	input  wire logic                    rst_b,
	input  wire logic                    prog_mode_pin,
	input  wire logic                    cmd_valid,
	input  wire logic                    cmd_from_prog,
	input  wire logic [3:0]              cmd_code,
	input  wire logic [`FSG_BLK_W-1:0]   cmd_blk,
	input  wire logic [2:0]              cmd_sec,
	input  wire logic                    flash_done,
	input  wire logic                    flash_ok,
	output logic                         cmd_busy,
	output logic                         cmd_accept,
	output logic                         cmd_reject,
	output logic                         cmd_fail,
	output logic                         flash_start,
	output logic [3:0]                   flash_op,
	output logic [`FSG_ADDR_W-1:0]       flash_base,
	output logic [`FSG_ADDR_W-1:0]       flash_size,
	output logic                         flash_whole,
	output logic [2:0]                   sec_flags
);

	// =====================================================
	// Mode pin synchroniser
	logic                   mode_meta_r;
	logic                   mode_sync_r;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			mode_meta_r <= 1'b0;
			mode_sync_r <= 1'b0;
		end else begin
			mode_meta_r <= prog_mode_pin;
			mode_sync_r <= mode_meta_r;
		end
	end

	// =====================================================
	// Command decode
	// Each flag forbids its own set of programmer commands; a command passes only if no
	// raised flag forbids it, so adding a flag can only shrink what is accepted.
	function automatic logic flag_forbids(input int idx, input logic [3:0] code);
		logic is_blk;
		is_blk = (code == fsg_pkg::FSG_CMD_BLK);
		case (idx)
			`FSG_SEC_BLK_BIT:  flag_forbids = is_blk;
			`FSG_SEC_CHIP_BIT: flag_forbids = is_blk || (code == fsg_pkg::FSG_CMD_CHIP);
			`FSG_SEC_PROG_BIT: flag_forbids = is_blk || (code == fsg_pkg::FSG_CMD_PROG);
			default:           flag_forbids = 1'b0;
		endcase
	endfunction

	// A function keeps the acceptance table in one place for both paths.
	function automatic logic cmd_allowed(input logic [3:0] code, input logic from_prog,
		input logic in_prog_mode, input logic blocked);
		cmd_allowed = 1'b0;
		if (from_prog && in_prog_mode) begin
			case (code)
				fsg_pkg::FSG_CMD_BLK:  cmd_allowed = !blocked;
				fsg_pkg::FSG_CMD_CHIP: cmd_allowed = !blocked;
				fsg_pkg::FSG_CMD_PROG: cmd_allowed = !blocked;
				fsg_pkg::FSG_CMD_SEC:  cmd_allowed = 1'b1;
				fsg_pkg::FSG_CMD_READ: cmd_allowed = 1'b1;
				default:               cmd_allowed = 1'b0;
			endcase
		end else if (!from_prog && !in_prog_mode) begin
			case (code)
				fsg_pkg::FSG_CMD_BLK:  cmd_allowed = 1'b1;
				fsg_pkg::FSG_CMD_PROG: cmd_allowed = 1'b1;
				fsg_pkg::FSG_CMD_READ: cmd_allowed = 1'b1;
				default:               cmd_allowed = 1'b0;
			endcase
		end
	endfunction

	logic [`FSG_ADDR_W-1:0] map_base;
	logic [`FSG_ADDR_W-1:0] map_size;

	fsg_blk_map u_map (
		.blk  (cmd_blk),
		.base (map_base),
		.size (map_size)
	);

	// =====================================================
	// Command sequencer
	fsg_pkg::fsg_state_e    state_r;
	fsg_pkg::fsg_state_e    state_nxt;
	logic                   ok_now;
	logic                   take;
	logic [3:0]             op_r;
	logic [2:0]             sec_r;
	logic [2:0]             sec_req_r;
	logic                   via_prog_r;
	logic [2:0]             forbid;

	generate
		for (genvar i = 0; i < 3; i++) begin : g_forbid
			assign forbid[i] = sec_r[i] && flag_forbids(i, cmd_code);
		end
	endgenerate

	assign ok_now = cmd_allowed(cmd_code, cmd_from_prog, mode_sync_r, |forbid);
	assign take   = (state_r == fsg_pkg::FSG_ST_IDLE) && cmd_valid;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			fsg_pkg::FSG_ST_IDLE: begin
				if (cmd_valid) begin
					state_nxt = ok_now ? fsg_pkg::FSG_ST_BUSY : fsg_pkg::FSG_ST_REJ;
				end
			end
			fsg_pkg::FSG_ST_BUSY: begin
				if (flash_done) begin
					state_nxt = fsg_pkg::FSG_ST_DONE;
				end
			end
			fsg_pkg::FSG_ST_DONE: state_nxt = fsg_pkg::FSG_ST_IDLE;
			fsg_pkg::FSG_ST_REJ:  state_nxt = fsg_pkg::FSG_ST_IDLE;
			default:              state_nxt = fsg_pkg::FSG_ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= fsg_pkg::FSG_ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			op_r       <= 4'h0;
			sec_req_r  <= 3'h0;
			via_prog_r <= 1'b0;
		end else if (take && ok_now) begin
			op_r       <= cmd_code;
			sec_req_r  <= cmd_sec;
			via_prog_r <= cmd_from_prog && mode_sync_r;
		end
	end

	// A whole-array erase has no range that fits the size field, so the range reads as zero
	// and the whole flag alone tells the engine what to erase.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_base <= '0;
			flash_size <= '0;
		end else if (take && ok_now) begin
			if (cmd_code == fsg_pkg::FSG_CMD_CHIP) begin
				flash_base <= '0;
				flash_size <= '0;
			end else begin
				flash_base <= map_base;
				flash_size <= map_size;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_whole <= 1'b0;
		end else if (take && ok_now) begin
			flash_whole <= (cmd_code == fsg_pkg::FSG_CMD_CHIP);
		end
	end

	// =====================================================
	// Flash engine handshake
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_start <= 1'b0;
		end else begin
			flash_start <= take && ok_now;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flash_op <= 4'h0;
		end else if (take && ok_now) begin
			flash_op <= cmd_code;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_busy <= 1'b0;
		end else begin
			cmd_busy <= (state_nxt != fsg_pkg::FSG_ST_IDLE);
		end
	end

	// A refused command never reaches the engine; its answer comes one cycle after the request.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_reject <= 1'b0;
		end else begin
			cmd_reject <= take && !ok_now;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_accept <= 1'b0;
		end else begin
			cmd_accept <= (state_r == fsg_pkg::FSG_ST_BUSY) && flash_done && flash_ok;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_fail <= 1'b0;
		end else begin
			cmd_fail <= (state_r == fsg_pkg::FSG_ST_BUSY) && flash_done && !flash_ok;
		end
	end

	// =====================================================
	// Prohibition flags
	// Flags only change on a completed programmer-mode operation, so a self
	// programming command can never reach them.
	logic                   fin_ok;
	logic                   chip_done;
	logic                   sec_done;
	logic [2:0]             sec_nxt;

	// Requiring programmer mode both at acceptance and at completion stops a command that was
	// taken just before the mode pin fell from changing flags once self programming has begun.
	assign fin_ok    = (state_r == fsg_pkg::FSG_ST_BUSY) && flash_done && flash_ok
		&& mode_sync_r && via_prog_r;
	assign chip_done = fin_ok && (op_r == fsg_pkg::FSG_CMD_CHIP);
	assign sec_done  = fin_ok && (op_r == fsg_pkg::FSG_CMD_SEC);

	// One function serves all three flags; only the chip erase flag is never cleared by chip erase.
	function automatic logic flag_next(input int idx, input logic [2:0] cur, input logic req,
		input logic chip_ok, input logic set_ok);
		flag_next = cur[idx];
		if (set_ok) begin
			flag_next = cur[idx] | req;
		end else if (chip_ok && !cur[`FSG_SEC_CHIP_BIT] && idx != `FSG_SEC_CHIP_BIT) begin
			flag_next = 1'b0;
		end
	endfunction

	generate
		for (genvar i = 0; i < 3; i++) begin : g_flag
			assign sec_nxt[i] = flag_next(i, sec_r, sec_req_r[i], chip_done, sec_done);
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_r <= `FSG_SEC_RST;
		end else begin
			sec_r <= sec_nxt;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			sec_flags <= `FSG_SEC_RST;
		end else begin
			sec_flags <= sec_r;
		end
	end

endmodule

// [tb/fsg_gate_asserts.sv]
// Port checks of the flash security command gate.
`timescale 1ns/1ps
`include "fsg_params.svh"
module fsg_gate_asserts (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        cmd_valid,
	input wire logic        cmd_from_prog,
	input wire logic [3:0]  cmd_code,
	input wire logic        cmd_busy,
	input wire logic        cmd_accept,
	input wire logic        cmd_reject,
	input wire logic        cmd_fail,
	input wire logic        flash_start,
	input wire logic [3:0]  flash_op,
	input wire logic [17:0] flash_base,
	input wire logic [17:0] flash_size,
	input wire logic        flash_whole,
	input wire logic [2:0]  sec_flags
);
	// ==========
	// Checks
	// An idle cycle without an answer pulse is where a request is taken.
	wire logic take = cmd_valid && !cmd_busy && !cmd_accept && !cmd_reject && !cmd_fail;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	property p_blk; take && cmd_from_prog && cmd_code == 4'h1 && sec_flags != 3'h0 |=> cmd_reject; endproperty
	a_blk: assert property (p_blk) else $error("block erase not refused");
	property p_chip; take && cmd_code == 4'h2 && sec_flags[1] |=> cmd_reject; endproperty
	a_chip: assert property (p_chip) else $error("chip erase not refused");
	property p_prog; take && cmd_from_prog && cmd_code == 4'h3 && sec_flags[2] |=> cmd_reject; endproperty
	a_prog: assert property (p_prog) else $error("program not refused");
	property p_user; take && !cmd_from_prog && (cmd_code == 4'h2 || cmd_code == 4'h4) |=> cmd_reject; endproperty
	a_user: assert property (p_user) else $error("user command not refused");
	property p_keep; sec_flags[1] |=> (sec_flags & $past(sec_flags)) == $past(sec_flags); endproperty
	a_keep: assert property (p_keep) else $error("locked flag cleared");
	property p_cause; $changed(sec_flags) |-> ($past(cmd_accept) || $past(cmd_accept, 2))
		&& (flash_op == 4'h2 || flash_op == 4'h4); endproperty
	a_cause: assert property (p_cause) else $error("flags changed without cause");
	property p_clear; cmd_accept && flash_whole && flash_op == 4'h2 |-> ##[1:2] sec_flags == 3'h0; endproperty
	a_clear: assert property (p_clear) else $error("chip erase kept flags");
	property p_size; flash_start && flash_op == 4'h1
		|-> flash_size == (flash_base < 18'h04000 ? `FSG_SMALL_BYTES : `FSG_LARGE_BYTES); endproperty
	a_size: assert property (p_size) else $error("block size wrong");
	property p_whole; flash_start && flash_op == 4'h2 |-> flash_whole && flash_base == 18'h00000; endproperty
	a_whole: assert property (p_whole) else $error("chip erase not whole");
endmodule
bind fsg_gate fsg_gate_asserts i_fsg_gate_asserts (.*);

// [tb/fsg_flash_model.sv]
// Flash engine model that ends each operation after a chosen delay.
`timescale 1ns/1ps
module fsg_flash_model (
	input  wire logic       core_clk,
	input  wire logic       rst_b,
	input  wire logic       flash_start,
	input  wire logic [3:0] dly,
	input  wire logic       ok_in,
	output logic            flash_done,
	output logic            flash_ok
);
	logic [3:0] cnt_r;
	// Status toggles outside the done pulse, so a stale value never passes as valid.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_r      <= 4'h0;
			flash_done <= 1'b0;
			flash_ok   <= 1'b0;
		end else begin
			cnt_r      <= flash_start ? dly : (cnt_r != 4'h0 ? cnt_r - 4'h1 : 4'h0);
			flash_done <= cnt_r == 4'h1;
			flash_ok   <= cnt_r == 4'h1 ? ok_in : ~flash_ok;
		end
	end
endmodule

// [tb/fsg_gate_tb.sv]
// Self-checking bench of the flash security command gate.
`timescale 1ns/1ps
`include "fsg_params.svh"
module fsg_gate_tb;
	logic        core_clk = 1'b0, rst_b = 1'b0, prog_mode_pin = 1'b1, cmd_valid = 1'b0, cmd_from_prog = 1'b1;
	logic        flash_done, flash_ok, ok_in = 1'b1, cmd_busy, cmd_accept, cmd_reject, cmd_fail;
	logic        flash_start, flash_whole;
	logic [3:0]  cmd_code = 4'h0, flash_op, dly = 4'h1;
	logic [2:0]  cmd_blk = 3'h0, cmd_sec = 3'h0, sec_flags;
	logic [17:0] flash_base, flash_size;
	int          error_cnt = 0, tests_run = 0, cyc = 0;
	localparam logic [3:0] BE = fsg_pkg::FSG_CMD_BLK, CE = fsg_pkg::FSG_CMD_CHIP, PR = fsg_pkg::FSG_CMD_PROG;
	localparam logic [3:0] SC = fsg_pkg::FSG_CMD_SEC, RD = fsg_pkg::FSG_CMD_READ;
	localparam logic [2:0] REJ = 3'h1, ACC = 3'h2, FL = 3'h4;
	fsg_gate        i_fsg_gate (.*);
	fsg_flash_model i_fsg_flash_model (.*);
	// ==========
	// Tasks
	initial forever #2 core_clk = ~core_clk;
	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// A hang counts as a mismatch; the whole run needs well under a thousand cycles.
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic run(input logic src, input logic [3:0] code, input logic [2:0] blk, sec, res);
		int n;
		n = 0;
		@(posedge core_clk);
		#1;
		{cmd_valid, cmd_from_prog, cmd_code, cmd_blk, cmd_sec} = {1'b1, src, code, blk, sec};
		@(posedge core_clk);
		#1;
		cmd_valid = 1'b0;
		chk({cmd_busy, flash_start}, {1'b1, res != REJ});
		while (!(cmd_accept | cmd_reject | cmd_fail) && n < 40) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk({cmd_fail, cmd_accept, cmd_reject}, res);
		while (cmd_busy !== 1'b0 && n < 80) begin
			@(posedge core_clk);
			#1;
			n++;
		end
	endtask
	task automatic set_mode(input logic m);
		prog_mode_pin = m;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	// ==========
	// Scenarios
	task automatic s_open();
		run(1, BE, 3'h3, 3'h0, ACC);
		chk(flash_op, BE);
		chk(flash_base, 18'h03000);
		chk(flash_size, `FSG_SMALL_BYTES);
		dly = 4'hf;
		run(1, BE, 3'h7, 3'h0, ACC);
		chk(flash_base, 18'h31000);
		chk(flash_size, `FSG_LARGE_BYTES);
		ok_in = 1'b0;
		run(1, PR, 3'h0, 3'h0, FL);
		ok_in = 1'b1;
		dly = 4'h1;
	endtask
	task automatic s_flags();
		run(1, SC, 3'h0, 3'h1, ACC);
		chk(sec_flags, 3'h1);
		run(1, BE, 3'h5, 3'h0, REJ);
		run(1, PR, 3'h0, 3'h0, ACC);
		run(1, SC, 3'h0, 3'h4, ACC);
		chk(sec_flags, 3'h5);
		run(1, PR, 3'h0, 3'h0, REJ);
		ok_in = 1'b0;
		run(1, CE, 3'h0, 3'h0, FL);
		chk(sec_flags, 3'h5);
		ok_in = 1'b1;
		run(1, CE, 3'h6, 3'h0, ACC);
		chk(flash_whole, 1'b1);
		chk(flash_base, 18'h00000);
		chk(sec_flags, 3'h0);
		run(1, BE, 3'h1, 3'h0, ACC);
		run(1, PR, 3'h0, 3'h0, ACC);
	endtask
	task automatic s_self();
		run(1, SC, 3'h0, 3'h5, ACC);
		set_mode(1'b0);
		run(0, BE, 3'h2, 3'h0, ACC);
		run(0, PR, 3'h0, 3'h0, ACC);
		run(0, CE, 3'h0, 3'h0, REJ);
		run(0, SC, 3'h0, 3'h2, REJ);
		run(1, SC, 3'h0, 3'h2, REJ);
		run(0, RD, 3'h0, 3'h0, ACC);
		chk(sec_flags, 3'h5);
		set_mode(1'b1);
	endtask
	task automatic s_lock();
		run(1, SC, 3'h0, 3'h2, ACC);
		chk(sec_flags, 3'h7);
		run(1, CE, 3'h0, 3'h0, REJ);
		run(1, BE, 3'h0, 3'h0, REJ);
		chk(sec_flags, 3'h7);
	endtask
	initial begin
		repeat (20) @(posedge core_clk);
		#1;
		rst_b = 1'b1;
		repeat (3) @(posedge core_clk);
		#1;
		chk({cmd_busy, cmd_accept, cmd_reject, cmd_fail, flash_start, sec_flags}, 8'h00);
		s_open();
		s_flags();
		s_self();
		s_lock();
		finish_test();
	end
endmodule
